// ==== hdl/rcg_pkg.sv ====
package rcg_pkg;
  localparam logic [3:0]  RCG_ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  RCG_ADDR_TRIM   = 4'h4;
  localparam int          RCG_DIV_LSB     = 16;
  localparam int          RCG_DIV_W       = 15;
  localparam int          RCG_ON_BIT      = 15;
  localparam int          RCG_STOP_IN_IDLE_BIT    = 13;
  localparam int          RCG_OE_BIT      = 12;
  localparam int          RCG_RUN_IN_SLEEP_BIT    = 11;
  localparam int          RCG_SW_BIT      = 9;
  localparam int          RCG_ACT_BIT     = 8;
  localparam int          RCG_TRIM_LSB    = 23;
  localparam int          RCG_TRIM_W      = 9;
  localparam int          RCG_NSRC        = 9;
  localparam logic [3:0]  RCG_SRC_SYS     = 4'h0;
  localparam logic [3:0]  RCG_SRC_PB      = 4'h1;
  localparam logic [31:0] RCG_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] RCG_TRIM_RESET  = 32'h0000_0000;
  localparam logic [1:0]  RCG_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RCG_RESP_SLVERR = 2'h2;
endpackage : rcg_pkg

// ==== hdl/rcg_src_mux.sv ====
`timescale 1ns/1ps
module rcg_src_mux
  import rcg_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [RCG_NSRC-1:0] src_i,
  output logic                     edge_o
);
  logic src_q;
  logic pick;
  // Reserved codes select nothing, so the divider sees no edges.
  assign pick = (sel_i < 4'(RCG_NSRC)) ? src_i[sel_i] : 1'b0;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) src_q <= 1'b0;
    else         src_q <= pick;
  end
  assign edge_o = pick & ~src_q;
endmodule : rcg_src_mux

// ==== hdl/rcg_frac_div.sv ====
`timescale 1ns/1ps
module rcg_frac_div
  import rcg_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  run_i,
  input  wire logic                  edge_i,
  input  wire logic [RCG_DIV_W-1:0]  div_i,
  input  wire logic [RCG_TRIM_W-1:0] trim_i,
  output logic                       clk_o
);
  logic [RCG_DIV_W-1:0]  cnt_q;
  logic [RCG_TRIM_W-1:0] acc_q;
  logic [RCG_TRIM_W:0]   acc_sum;
  logic                  out_q;
  logic                  extra;
  logic                  done;
  // The trim is spread by a phase accumulator: one extra source edge per carry.
  assign acc_sum = {1'b0, acc_q} + {1'b0, trim_i};
  assign extra   = acc_sum[RCG_TRIM_W];
  assign done    = (cnt_q >= div_i - 15'(!extra));
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= '0;
      acc_q <= '0;
      out_q <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt_q <= '0;
      acc_q <= '0;
      out_q <= 1'b0;
    end
    else if (edge_i)
    begin
      if (div_i == '0)
        out_q <= ~out_q;
      else if (done)
      begin
        cnt_q <= '0;
        acc_q <= acc_sum[RCG_TRIM_W-1:0];
        out_q <= ~out_q;
      end
      else
        cnt_q <= cnt_q + 15'd1;
    end
  end
  assign clk_o = out_q;
endmodule : rcg_frac_div

// ==== hdl/rcg_top.sv ====
`timescale 1ns/1ps
module rcg_top
  import rcg_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic [RCG_NSRC-1:0] src_clk_i,
  input  wire logic                idle_i,
  input  wire logic                sleep_i,
  input  wire logic [3:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [3:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic                     ref_clock_out_pin_o,
  output logic                     ref_clock_out_pin_oe_n_o,
  output logic                     ref_clock_o
);
  logic [31:0]           ref_clock_control_q;
  logic [RCG_TRIM_W-1:0] ref_divider_fraction_q;
  logic [RCG_DIV_W-1:0]  div_act_q;
  logic [RCG_TRIM_W-1:0] trim_act_q;
  logic                  sw_q;
  logic                  aw_q;
  logic [3:0]            awaddr_q;
  logic                  w_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;

  logic                  enable;
  logic                  stop_in_idle;
  logic                  pin_enable;
  logic                  run_in_sleep;
  logic [3:0]            ref_source_select;
  logic                  fabric_src;
  logic                  sleep_block;
  logic                  run;
  logic                  active;
  logic                  src_edge;
  logic                  gen_clk;
  logic                  do_wr;
  logic [31:0]           wmask;
  logic                  wr_ctrl;
  logic                  wr_trim;
  logic [31:0]           ctrl_new;
  logic [31:0]           ctrl_rd;
  logic [31:0]           trim_rd;
  logic                  sw_set;
  logic                  src_level;
  logic                  div_zero;
  logic                  out_clk_q;

  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] base);
    addr_hit = (a == base);
  endfunction : addr_hit

  assign enable            = ref_clock_control_q[RCG_ON_BIT];
  assign stop_in_idle      = ref_clock_control_q[RCG_STOP_IN_IDLE_BIT];
  assign pin_enable        = ref_clock_control_q[RCG_OE_BIT];
  assign run_in_sleep      = ref_clock_control_q[RCG_RUN_IN_SLEEP_BIT];
  assign ref_source_select = ref_clock_control_q[3:0];
  assign fabric_src  = (ref_source_select == RCG_SRC_SYS) || (ref_source_select == RCG_SRC_PB);
  // The core clocks stop in sleep anyway, so run-in-sleep cannot rescue them.
  assign sleep_block = sleep_i && (fabric_src || !run_in_sleep);
  assign run    = enable && !(idle_i && stop_in_idle) && !sleep_block;
  assign active = run;
  // A zero divisor bypasses the divider; the source level is retimed so the output stays a flop.
  assign src_level = (ref_source_select < 4'(RCG_NSRC)) ? src_clk_i[ref_source_select] : 1'b0;
  assign div_zero  = (div_act_q == '0);

  rcg_src_mux u_mux (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .sel_i  (ref_source_select),
    .src_i  (src_clk_i),
    .edge_o (src_edge)
  );

  rcg_frac_div u_div (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .run_i  (run),
    .edge_i (src_edge),
    .div_i  (div_act_q),
    .trim_i (trim_act_q),
    .clk_o  (gen_clk)
  );

  assign ref_clock_o              = out_clk_q;
  assign ref_clock_out_pin_o      = out_clk_q & pin_enable;
  assign ref_clock_out_pin_oe_n_o = ~pin_enable;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      out_clk_q <= 1'b0;
    else
      out_clk_q <= div_zero ? (run && src_level) : gen_clk;
  end

  assign do_wr   = aw_q && w_q && !bvalid_q;
  assign wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_ctrl = do_wr && addr_hit(awaddr_q, RCG_ADDR_CTRL);
  assign wr_trim = do_wr && addr_hit(awaddr_q, RCG_ADDR_TRIM);
  assign ctrl_new = (ref_clock_control_q & ~wmask) | (wdata_q & wmask);
  assign sw_set   = wr_ctrl && wmask[RCG_SW_BIT] && wdata_q[RCG_SW_BIT];
  // Unused bits are masked so they always read zero; the switch and active bits read live hardware state.
  assign ctrl_rd = {1'b0, ref_clock_control_q[30:16], enable, 1'b0, stop_in_idle, pin_enable,
                    run_in_sleep, 1'b0, sw_q, active, 4'h0, ref_source_select};
  assign trim_rd = {ref_divider_fraction_q, 23'h0};

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready  = !w_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_q     <= 1'b0;
      awaddr_q <= 4'h0;
      w_q      <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RCG_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_ctrl || wr_trim) ? RCG_RESP_OKAY : RCG_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RCG_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= addr_hit(s_axi_araddr, RCG_ADDR_CTRL) ? ctrl_rd :
                  addr_hit(s_axi_araddr, RCG_ADDR_TRIM) ? trim_rd : 32'h0000_0000;
      rresp_q  <= (addr_hit(s_axi_araddr, RCG_ADDR_CTRL) || addr_hit(s_axi_araddr, RCG_ADDR_TRIM))
                  ? RCG_RESP_OKAY : RCG_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Software fields; the switch and active bits are kept apart as hardware state.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ref_clock_control_q    <= RCG_CTRL_RESET;
      ref_divider_fraction_q <= RCG_TRIM_RESET[31:23];
    end
    else
    begin
      if (wr_ctrl)
        ref_clock_control_q <= ctrl_new;
      if (wr_trim)
        ref_divider_fraction_q <= (ref_divider_fraction_q & ~wmask[31:23]) | (wdata_q[31:23] & wmask[31:23]);
    end
  end

  // The switch completes two cycles after the request write, whatever the divider's count at that point.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sw_q       <= 1'b0;
      div_act_q  <= '0;
      trim_act_q <= '0;
    end
    else
    begin
      if (sw_set)
        sw_q <= 1'b1;
      else if (sw_q)
        sw_q <= 1'b0;
      if (!enable || sw_q)
      begin
        div_act_q  <= ref_clock_control_q[30:16];
        trim_act_q <= ref_divider_fraction_q;
      end
    end
  end

  property p_sw_clears;
    @(posedge clk_i) disable iff (!nrst_i) sw_set |=> sw_q ##1 !sw_q;
  endproperty
  a_sw_clears: assert property (p_sw_clears) else $error("switch request did not self-clear");

  property p_div_held;
    @(posedge clk_i) disable iff (!nrst_i) (enable && $past(enable) && !$past(sw_q)) |-> $stable(div_act_q);
  endproperty
  a_div_held: assert property (p_div_held) else $error("divisor changed without switch");

  property p_trim_held;
    @(posedge clk_i) disable iff (!nrst_i) (enable && $past(enable) && !$past(sw_q)) |-> $stable(trim_act_q);
  endproperty
  a_trim_held: assert property (p_trim_held) else $error("trim changed without switch");

  property p_off_quiet;
    @(posedge clk_i) disable iff (!nrst_i) !enable ##1 !enable |-> !gen_clk;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("clock runs while disabled");

  property p_idle_stop;
    @(posedge clk_i) disable iff (!nrst_i) (idle_i && stop_in_idle) |-> !active;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("active in idle with stop set");

  property p_pin_off;
    @(posedge clk_i) disable iff (!nrst_i) !pin_enable |-> (!ref_clock_out_pin_o && ref_clock_out_pin_oe_n_o);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while output disabled");

  property p_sleep_fabric;
    @(posedge clk_i) disable iff (!nrst_i) (sleep_i && fabric_src) |-> !active;
  endproperty
  a_sleep_fabric: assert property (p_sleep_fabric) else $error("fabric source active in sleep");

  property p_sleep_run;
    @(posedge clk_i) disable iff (!nrst_i) (enable && sleep_i && run_in_sleep && !fabric_src && !idle_i) |-> active;
  endproperty
  a_sleep_run: assert property (p_sleep_run) else $error("run-in-sleep ignored");

  property p_rsvd_zero;
    @(posedge clk_i) disable iff (!nrst_i) (ctrl_rd[31] == 1'b0) && (ctrl_rd[7:4] == 4'h0) && (trim_rd[22:0] == 23'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("unimplemented bits not zero");

  property p_pin_on;
    @(posedge clk_i) disable iff (!nrst_i) pin_enable |-> ((ref_clock_out_pin_o == ref_clock_o) && !ref_clock_out_pin_oe_n_o);
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pin not carrying the clock");

  property p_out_quiet;
    @(posedge clk_i) disable iff (!nrst_i) (!enable) [*3] |-> !ref_clock_o;
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("output runs while disabled");

  property p_act_off;
    @(posedge clk_i) disable iff (!nrst_i) !enable |-> !active;
  endproperty
  a_act_off: assert property (p_act_off) else $error("active while disabled");

  property p_act_on;
    @(posedge clk_i) disable iff (!nrst_i) (enable && !idle_i && !sleep_i) |-> active;
  endproperty
  a_act_on: assert property (p_act_on) else $error("not active while enabled");

  property p_stop_in_idle_run;
    @(posedge clk_i) disable iff (!nrst_i) (enable && idle_i && !stop_in_idle && !sleep_i) |-> active;
  endproperty
  a_stop_in_idle_run: assert property (p_stop_in_idle_run) else $error("stopped in idle without stop bit");

  property p_idle_quiet;
    @(posedge clk_i) disable iff (!nrst_i) (idle_i && stop_in_idle) [*3] |-> !ref_clock_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output runs in idle with stop set");

  property p_sleep_stop;
    @(posedge clk_i) disable iff (!nrst_i) (sleep_i && !run_in_sleep) |-> !active;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("active in sleep without run bit");

  property p_sleep_quiet;
    @(posedge clk_i) disable iff (!nrst_i) (sleep_i && !run_in_sleep) [*3] |-> !ref_clock_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("output runs in sleep without run bit");

  property p_fabric_quiet;
    @(posedge clk_i) disable iff (!nrst_i) (sleep_i && fabric_src) [*3] |-> !ref_clock_o;
  endproperty
  a_fabric_quiet: assert property (p_fabric_quiet) else $error("fabric source output runs in sleep");

  property p_sw_rose;
    @(posedge clk_i) disable iff (!nrst_i) $rose(sw_q) |-> $past(sw_set);
  endproperty
  a_sw_rose: assert property (p_sw_rose) else $error("switch started without a request write");

  property p_div_load;
    @(posedge clk_i) disable iff (!nrst_i) (!enable || sw_q) |=> (div_act_q == $past(ref_clock_control_q[30:16]));
  endproperty
  a_div_load: assert property (p_div_load) else $error("divisor not applied");

  property p_trim_load;
    @(posedge clk_i) disable iff (!nrst_i) (!enable || sw_q) |=> (trim_act_q == $past(ref_divider_fraction_q));
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not applied");

  property p_rsvd_quiet;
    @(posedge clk_i) disable iff (!nrst_i) (ref_source_select >= 4'(RCG_NSRC)) |-> !src_edge;
  endproperty
  a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("reserved select produced an edge");

  property p_src_pick;
    @(posedge clk_i) disable iff (!nrst_i) src_edge |-> src_level;
  endproperty
  a_src_pick: assert property (p_src_pick) else $error("edge from an unselected source");

  property p_pass;
    @(posedge clk_i) disable iff (!nrst_i) (run && div_zero) |=> (ref_clock_o == $past(src_level));
  endproperty
  a_pass: assert property (p_pass) else $error("zero divisor does not pass the source");

  property p_div_follow;
    @(posedge clk_i) disable iff (!nrst_i) !div_zero |=> (ref_clock_o == $past(gen_clk));
  endproperty
  a_div_follow: assert property (p_div_follow) else $error("output does not follow the divider");
endmodule : rcg_top

// ==== dv/rcg_ref_sink.sv ====
`timescale 1ns/1ps
module rcg_ref_sink (
  input  wire logic        clk_i,
  input  wire logic        pin_i,
  input  wire logic        oe_n_i,
  output logic [31:0]      edges_o
);
  logic        pin_q = 1'b0;
  logic [31:0] cnt_q = 32'h0;
  // A pin that is not driven is read as low, as if held by a pull-down, so it shows no edges.
  wire  pin_w = oe_n_i ? 1'b0 : pin_i;
  assign edges_o = cnt_q;
  always @(posedge clk_i)
  begin
    pin_q <= pin_w;
    if (pin_w && !pin_q) cnt_q <= cnt_q + 32'h1;
  end
endmodule : rcg_ref_sink

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb
  import rcg_pkg::*;
;
  logic                clk_i;
  logic                nrst_i = 1'b0;
  logic [RCG_NSRC-1:0] src_clk_i = '0;
  logic                idle_i = 1'b0;
  logic                sleep_i = 1'b0;
  logic [3:0]          s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0]         s_axi_wdata = 32'h0;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [31:0]         s_axi_rdata, pin_cnt, c;
  logic                ref_clock_out_pin_o, ref_clock_out_pin_oe_n_o, ref_clock_o, rc_q = 1'b0, act;
  logic [31:0]         rc_cnt = 32'h0;
  int                  cyc = 0, error_cnt = 0, n_tests = 0;
  // Bit 33 is idle, bit 32 is sleep, the rest is the control word.
  logic [33:0]         rows [13] = '{34'h0_0000_9000, 34'h0_0002_9001, 34'h0_0003_8002, 34'h0_0001_B003,
    34'h2_0001_B004, 34'h2_0001_9005, 34'h1_0001_9006, 34'h1_0001_9807, 34'h1_0001_9800,
    34'h1_0001_9801, 34'h0_0001_1008, 34'h0_0001_9009, 34'h0_0001_900F};

  rcg_top rcg_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .src_clk_i(src_clk_i), .idle_i(idle_i),
    .sleep_i(sleep_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ref_clock_out_pin_o(ref_clock_out_pin_o), .ref_clock_out_pin_oe_n_o(ref_clock_out_pin_oe_n_o),
    .ref_clock_o(ref_clock_o));
  rcg_ref_sink rcg_ref_sink_inst (.clk_i(clk_i), .pin_i(ref_clock_out_pin_o),
    .oe_n_i(ref_clock_out_pin_oe_n_o), .edges_o(pin_cnt));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Source k has a half period of k+2 cycles, so each of the RCG_NSRC sources gives a distinct rate.
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    for (int k = 0; k < RCG_NSRC; k++) src_clk_i[k] <= 1'((cyc / (k + 2)) % 2);
    rc_q <= ref_clock_o;
    if (ref_clock_o && !rc_q) rc_cnt <= rc_cnt + 32'h1;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  // Nonzero expected edge counts allow a slack of two, since window phase and trim carries jitter the count.
  function automatic logic near(input logic [31:0] n, input logic [31:0] e);
    return (e == 0) ? (n == 0) : (n + 2 >= e && n <= e + 2);
  endfunction : near

  task automatic meas(input logic run, input logic oe, input int k, input int dv, input int tr);
    logic [31:0] a, b, e;
    repeat (50) @(posedge clk_i);
    a = rc_cnt;
    b = pin_cnt;
    repeat (2000) @(posedge clk_i);
    e = run ? 32'(1024000 / (4 * (k + 2) * (dv == 0 ? 256 : dv * 512 + tr))) : 32'h0;
    chk({31'h0, near(rc_cnt - a, e)}, 32'h1);
    chk({31'h0, near(pin_cnt - b, oe ? e : 32'h0)}, 32'h1);
    chk({31'h0, ref_clock_out_pin_oe_n_o}, {31'h0, !oe});
  endtask : meas

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20) @(posedge clk_i);
    chk({29'h0, ref_clock_o, ref_clock_out_pin_o, ref_clock_out_pin_oe_n_o}, 32'h1);
    nrst_i <= 1'b1;
    rd(RCG_ADDR_CTRL, 32'h0, RCG_RESP_OKAY);
    rd(RCG_ADDR_TRIM, 32'h0, RCG_RESP_OKAY);
    wr(RCG_ADDR_TRIM, 32'hFFFF_FFFF, 4'hF, RCG_RESP_OKAY);
    rd(RCG_ADDR_TRIM, 32'hFF80_0000, RCG_RESP_OKAY);
    wr(RCG_ADDR_TRIM, 32'h0, 4'hF, RCG_RESP_OKAY);
    wr(RCG_ADDR_CTRL, 32'hFFFF_FFFF, 4'hF, RCG_RESP_OKAY);
    rd(RCG_ADDR_CTRL, 32'h7FFF_B90F, RCG_RESP_OKAY);
    wr(4'h8, 32'h1, 4'hF, RCG_RESP_SLVERR);
    rd(4'hC, 32'h0, RCG_RESP_SLVERR);
    $display("register test done");
    for (int i = 0; i < 13; i++)
    begin
      c = rows[i][31:0];
      act = c[15] && !(c[13] && rows[i][33]) && !(rows[i][32] && (!c[11] || c[3:0] < 4'h2));
      idle_i <= rows[i][33];
      sleep_i <= rows[i][32];
      // Only the enable byte is cleared, so select and divisor never change while active.
      wr(RCG_ADDR_CTRL, 32'h0, 4'h2, RCG_RESP_OKAY);
      wr(RCG_ADDR_CTRL, c & ~32'h8000, 4'hF, RCG_RESP_OKAY);
      wr(RCG_ADDR_CTRL, c, 4'hF, RCG_RESP_OKAY);
      rd(RCG_ADDR_CTRL, c | {23'h0, act, 8'h0}, RCG_RESP_OKAY);
      meas(act && c[3:0] < 4'h9, c[12], c[3:0], c[30:16], 0);
      $display("row %0d done", i);
    end
    wr(RCG_ADDR_CTRL, 32'h0, 4'h2, RCG_RESP_OKAY);
    wr(RCG_ADDR_CTRL, 32'h0001_3008, 4'hF, RCG_RESP_OKAY);
    wr(RCG_ADDR_CTRL, 32'h0001_B008, 4'hF, RCG_RESP_OKAY);
    idle_i <= 1'b1;
    rd(RCG_ADDR_CTRL, 32'h0001_B008, RCG_RESP_OKAY);
    meas(1'b0, 1'b1, 8, 1, 0);
    wr(RCG_ADDR_TRIM, 32'h8000_0000, 4'hF, RCG_RESP_OKAY);
    wr(RCG_ADDR_CTRL, 32'h0004_B008, 4'hF, RCG_RESP_OKAY);
    idle_i <= 1'b0;
    meas(1'b1, 1'b1, 8, 1, 0);
    rd(RCG_ADDR_CTRL, 32'h0004_B108, RCG_RESP_OKAY);
    idle_i <= 1'b1;
    wr(RCG_ADDR_CTRL, 32'h0004_B208, 4'hF, RCG_RESP_OKAY);
    rd(RCG_ADDR_CTRL, 32'h0004_B008, RCG_RESP_OKAY);
    idle_i <= 1'b0;
    meas(1'b1, 1'b1, 8, 4, 256);
    idle_i <= 1'b1;
    wr(RCG_ADDR_CTRL, 32'h0001_0000, 4'hC, RCG_RESP_OKAY);
    idle_i <= 1'b0;
    rd(RCG_ADDR_CTRL, 32'h0001_B108, RCG_RESP_OKAY);
    meas(1'b1, 1'b1, 8, 4, 256);
    $display("switch test done");
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({29'h0, ref_clock_o, ref_clock_out_pin_o, ref_clock_out_pin_oe_n_o}, 32'h1);
    nrst_i <= 1'b1;
    rd(RCG_ADDR_CTRL, 32'h0, RCG_RESP_OKAY);
    rd(RCG_ADDR_TRIM, 32'h0, RCG_RESP_OKAY);
    meas(1'b0, 1'b0, 0, 0, 0);
    $display("reset test done");
    give_verdict();
  end

  initial
  begin
    repeat (80000) @(posedge clk_i);
    error_cnt++;
    give_verdict();
  end
endmodule : tb
